//--- rtl/tpc_defines.svh
// Purpose: Offsets, reset values and sizes of the pixel correction stage.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus.
// Notes: Definitions only.
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH

`define TPC_OFS_MODE      8'h00
`define TPC_OFS_PAGE      8'h04
`define TPC_OFS_FILE_COLD 8'h08
`define TPC_OFS_FILE_WARM 8'h0c
`define TPC_OFS_FILE_SETV 8'h10
`define TPC_OFS_SETV_COLD 8'h14
`define TPC_OFS_SETV_WARM 8'h18
`define TPC_OFS_STATUS    8'h1c

`define TPC_RST_MODE      3'h0
`define TPC_RST_PAGE      2'h0
`define TPC_RST_FILE      16'h0000
`define TPC_RST_SETV      16'h0000

`define TPC_SETV_MASK     16'hfff0
`define TPC_PAGES         4
`define TPC_PAGE_W        2
`define TPC_PIX_AW        8
`define TPC_MEM_AW        10
`define TPC_STAT_BUSY     3

`endif

//--- rtl/tpc_pkg.sv
// Purpose: Types and shared arithmetic of the pixel correction stage.
// Assumes: 16-bit pixels and set values.
// Notes: Saturation is shared by datapath and checks.
package tpc_pkg;

  typedef enum logic [2:0] {
    TPC_PASS      = 3'b000,
    TPC_TWO_POINT = 3'b001,
    TPC_SHOW_COLD = 3'b010,
    TPC_SHOW_WARM = 3'b011,
    TPC_ONE_COLD  = 3'b100,
    TPC_ONE_WARM  = 3'b101
  } tpc_mode_type;

  // Clamps a wide signed result into the unsigned pixel range.
  function automatic logic [15:0] tpc_sat16(input logic signed [35:0] v);
    logic [15:0] r;
    if (v < 36'sh0) begin
      r = 16'h0000;
    end else if (v > 36'sh0ffff) begin
      r = 16'hffff;
    end else begin
      r = v[15:0];
    end
    return r;
  endfunction : tpc_sat16

  function automatic logic signed [35:0] tpc_wide(input logic [15:0] v);
    return $signed({20'h00000, v});
  endfunction : tpc_wide

endpackage : tpc_pkg

//--- rtl/tpc_ref_mem.sv
// Purpose: One reference image store, all pages, one word per pixel.
// Assumes: Write and read ports on the same clock.
// Notes: Read data leave a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defines.svh"

module tpc_ref_mem (
  input  wire logic                   clk_i,
  input  wire logic                   we_i,
  input  wire logic [`TPC_MEM_AW-1:0] waddr_i,
  input  wire logic [15:0]            wdata_i,
  input  wire logic [`TPC_MEM_AW-1:0] raddr_i,
  output var  logic [15:0]            rdata_o
);

  logic [15:0] mem_r [1 << `TPC_MEM_AW];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_r[raddr_i];
  end

endmodule : tpc_ref_mem
`default_nettype wire

//--- rtl/tpc_corr_arith.sv
// Purpose: Per-pixel arithmetic of the correction modes, one stage.
// Assumes: Mode and set values are already frame-stable and masked.
// Notes: The two-point divide is combinational and sets the clock limit.
`timescale 1ns/1ps
`default_nettype none

module tpc_corr_arith (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              valid_i,
  input  wire logic              sof_i,
  input  wire tpc_pkg::tpc_mode_type mode_i,
  input  wire logic [15:0]       pix_i,
  input  wire logic [15:0]       cold_i,
  input  wire logic [15:0]       warm_i,
  input  wire logic [15:0]       setc_i,
  input  wire logic [15:0]       setw_i,
  output var  logic              valid_o,
  output var  logic              sof_o,
  output var  logic [15:0]       pix_o
);

  logic        valid_nxt;
  logic        sof_nxt;
  logic [15:0] pix_nxt;
  logic signed [17:0] num;
  logic signed [17:0] gain;
  logic signed [17:0] span;
  logic signed [35:0] quot;

  always_comb begin
    num  = $signed({2'b00, pix_i}) - $signed({2'b00, cold_i});
    gain = $signed({2'b00, setw_i}) - $signed({2'b00, setc_i});
    span = $signed({2'b00, warm_i}) - $signed({2'b00, cold_i});
    quot = 36'sh0;
    valid_nxt = valid_i;
    sof_nxt   = sof_i & valid_i;
    case (mode_i)
      tpc_pkg::TPC_PASS: pix_nxt = pix_i;
      tpc_pkg::TPC_TWO_POINT: begin
        // A flat pixel has no slope; it is pinned to the cold set value.
        if (span == 18'sh0) begin
          pix_nxt = setc_i;
        end else begin
          quot    = (36'(num) * 36'(gain)) / 36'(span);
          pix_nxt = tpc_pkg::tpc_sat16(quot + tpc_pkg::tpc_wide(setc_i));
        end
      end
      tpc_pkg::TPC_SHOW_COLD: pix_nxt = cold_i;
      tpc_pkg::TPC_SHOW_WARM: pix_nxt = warm_i;
      tpc_pkg::TPC_ONE_COLD: pix_nxt = tpc_pkg::tpc_sat16(
        tpc_pkg::tpc_wide(pix_i) - tpc_pkg::tpc_wide(cold_i)
        + tpc_pkg::tpc_wide(setc_i));
      tpc_pkg::TPC_ONE_WARM: pix_nxt = tpc_pkg::tpc_sat16(
        tpc_pkg::tpc_wide(pix_i) - tpc_pkg::tpc_wide(warm_i)
        + tpc_pkg::tpc_wide(setw_i));
      default: pix_nxt = pix_i;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      sof_o   <= 1'b0;
      pix_o   <= 16'h0000;
    end else begin
      valid_o <= valid_nxt;
      sof_o   <= sof_nxt;
      pix_o   <= pix_nxt;
    end
  end

endmodule : tpc_corr_arith
`default_nettype wire

//--- rtl/tpc_two_point_corr.sv
// Purpose: Non-uniformity correction stage of a thermal pixel stream.
// Assumes: Pixel stream and reference loader run on clk_i, no stalls.
// Notes: Output follows input by two cycles in every mode.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defines.svh"

module tpc_two_point_corr (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output var  logic [31:0] dat_o,
  output var  logic        ack_o,
  input  wire logic        pix_valid_i,
  input  wire logic        pix_sof_i,
  input  wire logic [15:0] pix_data_i,
  output var  logic        pix_valid_o,
  output var  logic        pix_sof_o,
  output var  logic [15:0] pix_data_o,
  output var  logic        ld_req_o,
  output var  logic        ld_warm_o,
  output var  logic [15:0] ld_file_o,
  output var  logic [1:0]  ld_page_o,
  input  wire logic        ld_we_i,
  input  wire logic [7:0]  ld_addr_i,
  input  wire logic [15:0] ld_data_i,
  input  wire logic        ld_done_i
);

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  logic [31:0] dat_nxt;
  logic        ack_nxt;
  tpc_pkg::tpc_mode_type mode_r, mode_nxt;
  logic [1:0]  page_r, page_nxt;
  logic [15:0] file_cold_r, file_cold_nxt;
  logic [15:0] file_warm_r, file_warm_nxt;
  logic [15:0] file_setv_r, file_setv_nxt;
  logic [15:0] setc_r [`TPC_PAGES];
  logic [15:0] setc_nxt [`TPC_PAGES];
  logic [15:0] setw_r [`TPC_PAGES];
  logic [15:0] setw_nxt [`TPC_PAGES];
  logic        busy_r, busy_nxt;
  logic        ld_req_nxt;
  logic        ld_warm_nxt;
  logic [15:0] ld_file_nxt;
  logic [1:0]  ld_page_nxt;
  logic        wr;
  tpc_pkg::tpc_mode_type act_mode_r, act_mode_nxt;

  // The write lands on the edge that the master sees ack high.
  always_comb begin
    wr       = cyc_i & stb_i & we_i & ack_o;
    ack_nxt  = cyc_i & stb_i & ~ack_o;
    mode_nxt = mode_r;
    page_nxt = page_r;
    file_cold_nxt = file_cold_r;
    file_warm_nxt = file_warm_r;
    file_setv_nxt = file_setv_r;
    setc_nxt = setc_r;
    setw_nxt = setw_r;
    ld_req_nxt  = 1'b0;
    ld_warm_nxt = ld_warm_o;
    ld_file_nxt = ld_file_o;
    ld_page_nxt = ld_page_o;
    // A new request in the same cycle as done keeps the stage busy.
    busy_nxt = busy_r & ~ld_done_i;
    if (wr) begin
      case (adr_i)
        `TPC_OFS_MODE: if (sel_i[0]) begin
          mode_nxt = tpc_pkg::tpc_mode_type'(dat_i[2:0]);
        end
        `TPC_OFS_PAGE: if (sel_i[0]) begin
          page_nxt = dat_i[1:0];
        end
        `TPC_OFS_FILE_COLD: begin
          file_cold_nxt = merge16(file_cold_r, dat_i, sel_i);
          ld_req_nxt  = 1'b1;
          ld_warm_nxt = 1'b0;
          ld_file_nxt = file_cold_nxt;
          ld_page_nxt = page_r;
          busy_nxt    = 1'b1;
        end
        `TPC_OFS_FILE_WARM: begin
          file_warm_nxt = merge16(file_warm_r, dat_i, sel_i);
          ld_req_nxt  = 1'b1;
          ld_warm_nxt = 1'b1;
          ld_file_nxt = file_warm_nxt;
          ld_page_nxt = page_r;
          busy_nxt    = 1'b1;
        end
        `TPC_OFS_FILE_SETV: begin
          file_setv_nxt = merge16(file_setv_r, dat_i, sel_i);
        end
        `TPC_OFS_SETV_COLD: begin
          setc_nxt[page_r] = merge16(setc_r[page_r], dat_i, sel_i);
        end
        `TPC_OFS_SETV_WARM: begin
          setw_nxt[page_r] = merge16(setw_r[page_r], dat_i, sel_i);
        end
        default: ;
      endcase
    end
    case (adr_i)
      `TPC_OFS_MODE:      dat_nxt = {29'h0, mode_r};
      `TPC_OFS_PAGE:      dat_nxt = {30'h0, page_r};
      `TPC_OFS_FILE_COLD: dat_nxt = {16'h0, file_cold_r};
      `TPC_OFS_FILE_WARM: dat_nxt = {16'h0, file_warm_r};
      `TPC_OFS_FILE_SETV: dat_nxt = {16'h0, file_setv_r};
      `TPC_OFS_SETV_COLD: dat_nxt = {16'h0, setc_r[page_r]};
      `TPC_OFS_SETV_WARM: dat_nxt = {16'h0, setw_r[page_r]};
      `TPC_OFS_STATUS:    dat_nxt = {28'h0, busy_r, act_mode_r};
      default:            dat_nxt = 32'h0;
    endcase
    if (!ack_nxt) begin
      dat_nxt = 32'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o       <= 1'b0;
      dat_o       <= 32'h0;
      mode_r      <= tpc_pkg::tpc_mode_type'(`TPC_RST_MODE);
      page_r      <= `TPC_RST_PAGE;
      file_cold_r <= `TPC_RST_FILE;
      file_warm_r <= `TPC_RST_FILE;
      file_setv_r <= `TPC_RST_FILE;
      setc_r      <= '{default: `TPC_RST_SETV};
      setw_r      <= '{default: `TPC_RST_SETV};
      busy_r      <= 1'b0;
      ld_req_o    <= 1'b0;
      ld_warm_o   <= 1'b0;
      ld_file_o   <= `TPC_RST_FILE;
      ld_page_o   <= `TPC_RST_PAGE;
    end else begin
      ack_o       <= ack_nxt;
      dat_o       <= dat_nxt;
      mode_r      <= mode_nxt;
      page_r      <= page_nxt;
      file_cold_r <= file_cold_nxt;
      file_warm_r <= file_warm_nxt;
      file_setv_r <= file_setv_nxt;
      setc_r      <= setc_nxt;
      setw_r      <= setw_nxt;
      busy_r      <= busy_nxt;
      ld_req_o    <= ld_req_nxt;
      ld_warm_o   <= ld_warm_nxt;
      ld_file_o   <= ld_file_nxt;
      ld_page_o   <= ld_page_nxt;
    end
  end

  // Frame-stable configuration and the pixel address walk.
  logic [15:0] act_setc_r, act_setc_nxt;
  logic [15:0] act_setw_r, act_setw_nxt;
  logic [1:0]  act_page_r, act_page_nxt;
  logic [7:0]  pix_addr_r, pix_addr_nxt;
  logic        frame_go;
  tpc_pkg::tpc_mode_type cfg_mode;
  logic [15:0] cfg_setc;
  logic [15:0] cfg_setw;
  logic [1:0]  cfg_page;
  logic [7:0]  rd_addr;
  logic        s1_valid_r, s1_sof_r;
  logic [15:0] s1_data_r, s1_setc_r, s1_setw_r;
  tpc_pkg::tpc_mode_type s1_mode_r;
  logic [15:0] cold_rd, warm_rd;

  always_comb begin
    frame_go = pix_valid_i & pix_sof_i;
    // The frame's first pixel already sees the new settings.
    cfg_mode = frame_go ? mode_r : act_mode_r;
    cfg_setc = frame_go ? (setc_r[page_r] & `TPC_SETV_MASK) : act_setc_r;
    cfg_setw = frame_go ? (setw_r[page_r] & `TPC_SETV_MASK) : act_setw_r;
    cfg_page = frame_go ? page_r : act_page_r;
    act_mode_nxt = cfg_mode;
    act_setc_nxt = cfg_setc;
    act_setw_nxt = cfg_setw;
    act_page_nxt = cfg_page;
    rd_addr      = frame_go ? 8'h00 : pix_addr_r;
    pix_addr_nxt = pix_valid_i ? rd_addr + 8'h01 : pix_addr_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_mode_r <= tpc_pkg::tpc_mode_type'(`TPC_RST_MODE);
      act_setc_r <= `TPC_RST_SETV;
      act_setw_r <= `TPC_RST_SETV;
      act_page_r <= `TPC_RST_PAGE;
      pix_addr_r <= 8'h00;
      s1_valid_r <= 1'b0;
      s1_sof_r   <= 1'b0;
      s1_data_r  <= 16'h0000;
      s1_mode_r  <= tpc_pkg::TPC_PASS;
      s1_setc_r  <= 16'h0000;
      s1_setw_r  <= 16'h0000;
    end else begin
      act_mode_r <= act_mode_nxt;
      act_setc_r <= act_setc_nxt;
      act_setw_r <= act_setw_nxt;
      act_page_r <= act_page_nxt;
      pix_addr_r <= pix_addr_nxt;
      s1_valid_r <= pix_valid_i;
      s1_sof_r   <= pix_sof_i;
      s1_data_r  <= pix_data_i;
      s1_mode_r  <= cfg_mode;
      s1_setc_r  <= cfg_setc;
      s1_setw_r  <= cfg_setw;
    end
  end

  // Loader writes go only to the page and image named by the request.
  tpc_ref_mem u_cold (
    .clk_i   (clk_i),
    .we_i    (ld_we_i & busy_r & ~ld_warm_o),
    .waddr_i ({ld_page_o, ld_addr_i}),
    .wdata_i (ld_data_i),
    .raddr_i ({cfg_page, rd_addr}),
    .rdata_o (cold_rd)
  );

  tpc_ref_mem u_warm (
    .clk_i   (clk_i),
    .we_i    (ld_we_i & busy_r & ld_warm_o),
    .waddr_i ({ld_page_o, ld_addr_i}),
    .wdata_i (ld_data_i),
    .raddr_i ({cfg_page, rd_addr}),
    .rdata_o (warm_rd)
  );

  tpc_corr_arith u_arith (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .valid_i (s1_valid_r),
    .sof_i   (s1_sof_r),
    .mode_i  (s1_mode_r),
    .pix_i   (s1_data_r),
    .cold_i  (cold_rd),
    .warm_i  (warm_rd),
    .setc_i  (s1_setc_r),
    .setw_i  (s1_setw_r),
    .valid_o (pix_valid_o),
    .sof_o   (pix_sof_o),
    .pix_o   (pix_data_o)
  );

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_pass;
    pix_valid_i && cfg_mode == tpc_pkg::TPC_PASS
      |-> ##2 pix_valid_o && pix_data_o == $past(pix_data_i, 2);
  endproperty
  a_pass: assert property (p_pass) else $error("pass mode altered");

  property p_two_cold;
    s1_valid_r && s1_mode_r == tpc_pkg::TPC_TWO_POINT
      && s1_data_r == cold_rd && warm_rd != cold_rd
      |=> pix_data_o == $past(s1_setc_r);
  endproperty
  a_two_cold: assert property (p_two_cold) else $error("cold map");

  property p_two_warm;
    s1_valid_r && s1_mode_r == tpc_pkg::TPC_TWO_POINT
      && s1_data_r == warm_rd && warm_rd != cold_rd
      |=> pix_data_o == $past(s1_setw_r);
  endproperty
  a_two_warm: assert property (p_two_warm) else $error("warm map");

  property p_show_cold;
    s1_valid_r && s1_mode_r == tpc_pkg::TPC_SHOW_COLD
      |=> pix_data_o == $past(cold_rd);
  endproperty
  a_show_cold: assert property (p_show_cold) else $error("cold test");

  property p_show_warm;
    s1_valid_r && s1_mode_r == tpc_pkg::TPC_SHOW_WARM
      |=> pix_data_o == $past(warm_rd);
  endproperty
  a_show_warm: assert property (p_show_warm) else $error("warm test");

  property p_one_cold;
    s1_valid_r && s1_mode_r == tpc_pkg::TPC_ONE_COLD
      |=> pix_data_o == tpc_pkg::tpc_sat16($past(tpc_pkg::tpc_wide(s1_data_r)
        - tpc_pkg::tpc_wide(cold_rd) + tpc_pkg::tpc_wide(s1_setc_r)));
  endproperty
  a_one_cold: assert property (p_one_cold) else $error("one cold");

  property p_one_warm;
    s1_valid_r && s1_mode_r == tpc_pkg::TPC_ONE_WARM
      |=> pix_data_o == tpc_pkg::tpc_sat16($past(tpc_pkg::tpc_wide(s1_data_r)
        - tpc_pkg::tpc_wide(warm_rd) + tpc_pkg::tpc_wide(s1_setw_r)));
  endproperty
  a_one_warm: assert property (p_one_warm) else $error("one warm");

  property p_file_load;
    wr && adr_i == `TPC_OFS_FILE_COLD
      |=> ld_req_o && !ld_warm_o && ld_page_o == $past(page_r)
        && ld_file_o == file_cold_r ##1 !ld_req_o;
  endproperty
  a_file_load: assert property (p_file_load) else $error("no load");

  property p_setv_file;
    wr && adr_i == `TPC_OFS_FILE_SETV && sel_i == 4'hf
      |=> file_setv_r == $past(dat_i[15:0]);
  endproperty
  a_setv_file: assert property (p_setv_file) else $error("file n");

  property p_setv_page;
    wr && adr_i == `TPC_OFS_SETV_WARM && sel_i == 4'hf
      |=> setw_r[$past(page_r)] == $past(dat_i[15:0]);
  endproperty
  a_setv_page: assert property (p_setv_page) else $error("set page");

  property p_mask;
    (act_setc_r & ~`TPC_SETV_MASK) == 16'h0000
      && (s1_setw_r & ~`TPC_SETV_MASK) == 16'h0000;
  endproperty
  a_mask: assert property (p_mask) else $error("low bits used");

  property p_frame_hold;
    !frame_go |=> $stable(act_mode_r) && $stable(act_setc_r);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("mid frame");

  property p_file_reg;
    wr && adr_i == `TPC_OFS_FILE_WARM && sel_i == 4'hf
      |=> file_warm_r == $past(dat_i[15:0]) && ld_warm_o;
  endproperty
  a_file_reg: assert property (p_file_reg) else $error("file b");

  c_two: cover property (s1_valid_r && s1_mode_r == tpc_pkg::TPC_TWO_POINT);
  c_test: cover property (s1_valid_r && s1_mode_r == tpc_pkg::TPC_SHOW_WARM);
  c_load: cover property (ld_req_o ##[256:1000] ld_done_i);
  c_switch: cover property (frame_go && mode_r != act_mode_r);

endmodule : tpc_two_point_corr
`default_nettype wire

//--- verification/tpc_ref_loader_model.sv
// Purpose: Reference loader model beside the pixel correction stage.
// Assumes: Word of pixel k is the file number plus sixteen times k.
// Notes: Released lines toggle so that a stale word never matches.
`timescale 1ns/1ps
`default_nettype none
module tpc_ref_loader_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  input  wire logic        req_i,
  input  wire logic [15:0] file_i,
  output var  logic        we_o,
  output var  logic [7:0]  addr_o,
  output var  logic [15:0] data_o,
  output var  logic        done_o
);
  logic        run_r;
  logic [8:0]  idx_r;
  logic [15:0] file_r;
  // A new request restarts the count, so a retarget reloads in full.
  always_ff @(posedge clk_i) begin
    we_o   <= 1'b0;
    done_o <= 1'b0;
    if (rst_i) begin
      run_r  <= 1'b0;
      idx_r  <= 9'h000;
      addr_o <= 8'h00;
      data_o <= 16'h0000;
    end else if (req_i) begin
      run_r  <= 1'b1;
      idx_r  <= 9'h000;
      file_r <= file_i;
      data_o <= ~data_o;
    end else if (run_r && idx_r == 9'h100) begin
      run_r  <= 1'b0;
      done_o <= 1'b1;
      data_o <= ~data_o;
    end else if (run_r && !(slow_i && $urandom_range(0, 1) == 0)) begin
      we_o   <= 1'b1;
      addr_o <= idx_r[7:0];
      data_o <= file_r + {idx_r[7:0], 4'h0};
      idx_r  <= idx_r + 9'h001;
    end else begin
      data_o <= ~data_o;
      addr_o <= ~addr_o;
    end
  end
endmodule : tpc_ref_loader_model
`default_nettype wire

//--- verification/two_point_pixel_correction_tb_top.sv
// Purpose: Self-checking bench of the pixel correction stage.
// Assumes: The loader model answers every load request.
// Notes: Drivers queue expectations; monitors pop and compare.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defines.svh"
module two_point_pixel_correction_tb_top;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, slow = 0;
  logic        pv = 0, ps = 0, ack, pvo, pso, lreq, lwarm, lwe, ldone;
  logic [7:0]  adr = 0, laddr;
  logic [3:0]  sel = 0;
  logic [31:0] wdat = 0, rdat, g;
  logic [15:0] pd = 0, pdo, lfile, ldat;
  logic [1:0]  lpage, pg = 0;
  logic [2:0]  md = 0, act = 0;
  logic [32:0] re;
  logic [32:0] rd_q[$];
  logic [16:0] px_q[$];
  logic [18:0] ld_q[$];
  logic [15:0] cf[4], wf[4], sc[4], sw[4];
  int          err_count = 0, compares = 0;
  always #5 clk_i = ~clk_i;
  tpc_two_point_corr u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .pix_valid_i(pv), .pix_sof_i(ps), .pix_data_i(pd),
    .pix_valid_o(pvo), .pix_sof_o(pso), .pix_data_o(pdo),
    .ld_req_o(lreq), .ld_warm_o(lwarm), .ld_file_o(lfile),
    .ld_page_o(lpage), .ld_we_i(lwe), .ld_addr_i(laddr),
    .ld_data_i(ldat), .ld_done_i(ldone));
  tpc_ref_loader_model u_ldr (
    .clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .req_i(lreq),
    .file_i(lfile), .we_o(lwe), .addr_o(laddr), .data_o(ldat),
    .done_o(ldone));
  task automatic cmp(input string n, input logic [31:0] e, s);
    compares++;
    if (e !== s) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic chk_reg(input logic [31:0] e, s);
    cmp("register", e, s);
  endtask : chk_reg
  task automatic chk_pix(input logic [16:0] e, s);
    cmp("pixel", {15'h0, e}, {15'h0, s});
  endtask : chk_pix
  task automatic chk_ld(input logic [18:0] e, s);
    cmp("load request", {13'h0, e}, {13'h0, s});
  endtask : chk_ld
  task automatic stop_test;
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0) begin
      re = rd_q.pop_front();
      if (re[32]) chk_reg(re[31:0], rdat);
    end
    if (pvo === 1'b1) chk_pix(px_q.size() ? px_q.pop_front() : 'x, {pso, pdo});
    if (lreq === 1'b1) chk_ld(ld_q.size() ? ld_q.pop_front() : 'x,
                              {lwarm, lpage, lfile});
  end
  // Holds the request until ack is sampled, then idles one cycle.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    repeat (20) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (ack !== 1'b1) err_count++;
    g = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input bit c);
    rd_q.push_back({c, e});
    wb(1'b0, a, 32'h0, 4'hf);
  endtask : rd
  function automatic logic [15:0] expv(input logic [2:0] m,
                                       input logic [15:0] x, c, w, j, k);
    longint v, lx, lc, lw, lj, lk;
    lx = x;
    lc = c;
    lw = w;
    lj = j & `TPC_SETV_MASK;
    lk = k & `TPC_SETV_MASK;
    case (m)
      3'h1: v = (lw == lc) ? lj : lj + (lx - lc) * (lk - lj) / (lw - lc);
      3'h2: v = lc;
      3'h3: v = lw;
      3'h4: v = lx - lc + lj;
      3'h5: v = lx - lw + lk;
      default: v = lx;
    endcase
    return (v < 0) ? 16'h0 : (v > 65535) ? 16'hffff : v[15:0];
  endfunction : expv
  task automatic frame(input int n);
    logic [15:0] x, c, w;
    act = md;
    for (int k = 0; k < n; k++) begin
      x = 16'($urandom);
      c = cf[pg] + {8'(k), 4'h0};
      w = wf[pg] + {8'(k), 4'h0};
      // Pixels equal to a reference must land exactly on its set value.
      if (act == 3'h1 && k % 3 != 0) x = (k % 3 == 1) ? c : w;
      pv <= 1'b1;
      ps <= (k == 0);
      pd <= x;
      px_q.push_back({k == 0, expv(act, x, c, w, sc[pg], sw[pg])});
      @(posedge clk_i);
      if ($urandom_range(0, 3) == 0) begin
        pv <= 1'b0;
        pd <= ~x;
        @(posedge clk_i);
      end
    end
    pv <= 1'b0;
    ps <= 1'b0;
    @(posedge clk_i);
  endtask : frame
  task automatic load(input logic w, input logic [15:0] f);
    ld_q.push_back({w, pg, f});
    wr(w ? `TPC_OFS_FILE_WARM : `TPC_OFS_FILE_COLD, {16'h0, f});
    if (w) wf[pg] = f;
    else cf[pg] = f;
    rd(`TPC_OFS_STATUS, {28'h0, 1'b1, act}, 1'b1);
    repeat (500) begin
      rd(`TPC_OFS_STATUS, 32'h0, 1'b0);
      if (g[3] === 1'b0) break;
    end
    rd(`TPC_OFS_STATUS, {29'h0, act}, 1'b1);
  endtask : load
  task automatic setv(input logic [15:0] j, k);
    wr(`TPC_OFS_SETV_COLD, {16'h0, j});
    wr(`TPC_OFS_SETV_WARM, {16'h0, k});
    sc[pg] = j;
    sw[pg] = k;
    rd(`TPC_OFS_SETV_COLD, {16'h0, j}, 1'b1);
    rd(`TPC_OFS_SETV_WARM, {16'h0, k}, 1'b1);
  endtask : setv
  task automatic set_mode(input logic [2:0] m);
    wr(`TPC_OFS_MODE, {29'h0, m});
    md = m;
  endtask : set_mode
  initial begin
    #400000;
    err_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'he4c5779e));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'h0, 1'b1);
    load(1'b0, 16'h1000);
    slow <= 1'b1;
    load(1'b1, 16'h8000);
    rd(`TPC_OFS_FILE_COLD, 32'h1000, 1'b1);
    rd(`TPC_OFS_FILE_WARM, 32'h8000, 1'b1);
    wr(`TPC_OFS_FILE_SETV, 32'h0060);
    rd(`TPC_OFS_FILE_SETV, 32'h0060, 1'b1);
    // Low bits set on purpose: the datapath must drop them.
    setv(16'h1235, 16'h9008);
    wb(1'b1, `TPC_OFS_MODE, 32'h3, 4'h2);
    rd(`TPC_OFS_MODE, 32'h0, 1'b1);
    for (int m = 0; m < 8; m++) begin
      set_mode(3'(m));
      frame(20);
    end
    set_mode(3'h0);
    fork
      frame(24);
      begin
        repeat (8) @(posedge clk_i);
        set_mode(3'h2);
      end
    join
    frame(8);
    wr(`TPC_OFS_PAGE, 32'h1);
    pg = 2'h1;
    slow <= 1'b0;
    load(1'b0, 16'h2000);
    setv(16'h4000, 16'h7000);
    frame(10);
    wr(`TPC_OFS_PAGE, 32'h0);
    pg = 2'h0;
    rd(`TPC_OFS_SETV_COLD, 32'h1235, 1'b1);
    frame(10);
    set_mode(3'h4);
    frame(260);
    repeat (4) @(posedge clk_i);
    chk_pix(17'h0, 17'(px_q.size() + ld_q.size() + rd_q.size()));
    stop_test();
  end
endmodule : two_point_pixel_correction_tb_top
`default_nettype wire
